// >>> logic/ltct_pkg.sv
// How it works
// - counter2 irq mask gates overflow request
// - counter2 flag set on overflow, read clears
// - reload value copied into counter2 on overflow
// - counter2 live value readable, writes ignored
// - capture irq mask gates capture request
// - capture flag set on capture, capture read clears
// - period select picks 8000 or 16000 periods
// - counter1 irq mask gates overflow request
// - counter1 flag set on overflow, read clears
// - capture register resets zero, holds last capture
// - capture pin edge latches counter1 unless flagged
// - counter1 hidden, ticks per 32, wraps f9
// - counter2 ticks per 32 from reload, wraps ff
// - counters stop in deepest halt mode
package ltct_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [11:0] OFS_CSR2 = 12'h008;
	localparam logic [11:0] OFS_RELOAD = 12'h009;
	localparam logic [11:0] OFS_CNT2 = 12'h00a;
	localparam logic [11:0] OFS_CSR1 = 12'h00b;
	localparam logic [11:0] OFS_CAPTURE = 12'h00c;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h010;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h011;
	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_CNT2_MASK = 1;
	localparam int BIT_CNT2_FLAG = 0;
	localparam int BIT_CAP_MASK = 7;
	localparam int BIT_CAP_FLAG = 6;
	localparam int BIT_PERIOD = 5;
	localparam int BIT_CNT1_MASK = 4;
	localparam int BIT_CNT1_FLAG = 3;
	localparam int IRQ_CNT1 = 0;
	localparam int IRQ_CNT2 = 1;
	localparam int IRQ_CAP = 2;
	// ****************************************
	// reset values and timing
	// ****************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_IRQ_MASK = 3'h7;
	localparam int PRESCALE = 32;
	localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE - 1);
	localparam logic [7:0] CNT1_WRAP = 8'hf9;
	localparam logic [7:0] CNT2_WRAP = 8'hff;
endpackage

// >>> logic/ltct_flag.sv
`timescale 1ns/10ps
`default_nettype none
// sticky flag, set wins over clear
module ltct_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set,
	input wire logic clr,
	output logic flag
);
	logic next_flag;

	// next value: set beats clear
	always_comb
	begin
		next_flag = flag;
		if (clr)
			next_flag = 1'b0;
		if (set)
			next_flag = 1'b1;
	end

	// register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag <= 1'b0;
		else
			flag <= next_flag;
	end
endmodule
`default_nettype wire

// >>> logic/ltct_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ltct_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_pin,
	input wire logic halt_mode,
	output logic irq_counter1,
	output logic irq_counter2,
	output logic irq_capture,
	output logic irq
);
	// ****************************************
	// bus decode
	// ****************************************
	logic setup;
	logic access_wr;
	logic wr_lane0;
	logic mapped;
	assign setup = psel && !penable;
	assign access_wr = psel && penable && pready && pwrite;
	assign wr_lane0 = access_wr && pstrb[0];
	// word addresses; printed offsets are register indices
	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] o);
		is_reg = (a == {o[9:0], 2'b00});
	endfunction
	assign mapped = is_reg(paddr, ltct_pkg::OFS_CSR2)
		|| is_reg(paddr, ltct_pkg::OFS_RELOAD)
		|| is_reg(paddr, ltct_pkg::OFS_CNT2)
		|| is_reg(paddr, ltct_pkg::OFS_CSR1)
		|| is_reg(paddr, ltct_pkg::OFS_CAPTURE)
		|| is_reg(paddr, ltct_pkg::OFS_IRQ_STATUS)
		|| is_reg(paddr, ltct_pkg::OFS_IRQ_MASK);

	// ****************************************
	// control state
	// ****************************************
	logic [4:0] prescale;
	logic [7:0] count1;
	logic [7:0] count2;
	logic [7:0] reload;
	logic [7:0] capture;
	logic cnt2_mask;
	logic cap_mask;
	logic period_sel;
	logic cnt1_mask;
	logic period_half;
	logic pin_q;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic [4:0] next_prescale;
	logic [7:0] next_count1;
	logic [7:0] next_count2;
	logic [7:0] next_reload;
	logic [7:0] next_capture;
	logic next_cnt2_mask;
	logic next_cap_mask;
	logic next_period_sel;
	logic next_cnt1_mask;
	logic next_period_half;
	logic [2:0] next_irq_status;
	logic [2:0] next_irq_mask;
	logic tick;
	logic cnt1_wrap;
	logic ovf1;
	logic ovf2;
	logic cap_event;
	logic cnt1_flag;
	logic cnt2_flag;
	logic cap_flag;
	logic [2:0] events;
	logic pin_seen;
	logic clr1;
	logic clr2;
	logic clrc;

	assign tick = !halt_mode && (prescale == ltct_pkg::PRESCALE_LAST);
	assign cnt1_wrap = tick && (count1 == ltct_pkg::CNT1_WRAP);
	// long period counts two wraps: 16000 oscillator periods
	assign ovf1 = cnt1_wrap && (!period_sel || period_half);
	assign ovf2 = tick && (count2 == ltct_pkg::CNT2_WRAP);
	// any edge on pin, blocked while flag set
	assign cap_event = (capture_input_pin != pin_q) && pin_seen
		&& !cap_flag;
	assign events = {cap_event, ovf2, ovf1};
	// read-clear at setup edge, where prdata is taken: no lost event
	assign clr1 = setup && !pwrite && is_reg(paddr, ltct_pkg::OFS_CSR1);
	assign clr2 = setup && !pwrite && is_reg(paddr, ltct_pkg::OFS_CSR2);
	assign clrc = setup && !pwrite && is_reg(paddr, ltct_pkg::OFS_CAPTURE);

	// ****************************************
	// sticky flags
	// ****************************************
	ltct_flag u_flag1 (
		.pclk(pclk),
		.presetn(presetn),
		.set(ovf1),
		.clr(clr1),
		.flag(cnt1_flag)
	);
	ltct_flag u_flag2 (
		.pclk(pclk),
		.presetn(presetn),
		.set(ovf2),
		.clr(clr2),
		.flag(cnt2_flag)
	);
	ltct_flag u_flag_cap (
		.pclk(pclk),
		.presetn(presetn),
		.set(cap_event),
		.clr(clrc),
		.flag(cap_flag)
	);

	// next values of counters, registers and interrupt state
	always_comb
	begin
		next_prescale = halt_mode ? prescale : prescale + 5'h01;
		next_count1 = count1;
		next_period_half = period_half;
		next_count2 = count2;
		next_capture = capture;
		next_reload = reload;
		next_cnt2_mask = cnt2_mask;
		next_cap_mask = cap_mask;
		next_period_sel = period_sel;
		next_cnt1_mask = cnt1_mask;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		if (tick)
			next_count1 = cnt1_wrap ? 8'h00 : count1 + 8'h01;
		if (cnt1_wrap)
			next_period_half = !period_half;
		if (tick)
			next_count2 = ovf2 ? reload : count2 + 8'h01;
		if (cap_event)
			next_capture = count1;
		if (wr_lane0)
		begin
			if (is_reg(paddr, ltct_pkg::OFS_CSR2))
				next_cnt2_mask = pwdata[ltct_pkg::BIT_CNT2_MASK];
			if (is_reg(paddr, ltct_pkg::OFS_RELOAD))
				next_reload = pwdata[7:0];
			if (is_reg(paddr, ltct_pkg::OFS_CSR1))
			begin
				next_cap_mask = pwdata[ltct_pkg::BIT_CAP_MASK];
				next_period_sel = pwdata[ltct_pkg::BIT_PERIOD];
				next_cnt1_mask = pwdata[ltct_pkg::BIT_CNT1_MASK];
			end
			if (is_reg(paddr, ltct_pkg::OFS_IRQ_MASK))
				next_irq_mask = pwdata[2:0];
			if (is_reg(paddr, ltct_pkg::OFS_IRQ_STATUS))
				next_irq_status = irq_status & ~pwdata[2:0];
		end
		next_irq_status = next_irq_status | events; // set wins
	end

	// registers of counters and control
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale <= 5'h00;
			count1 <= ltct_pkg::RST_BYTE;
			count2 <= ltct_pkg::RST_BYTE;
			reload <= ltct_pkg::RST_BYTE;
			capture <= ltct_pkg::RST_BYTE;
			period_half <= 1'b0;
			cnt2_mask <= 1'b0;
			cap_mask <= 1'b0;
			period_sel <= 1'b0;
			cnt1_mask <= 1'b0;
			irq_mask <= ltct_pkg::RST_IRQ_MASK;
			irq_status <= 3'h0;
		end
		else
		begin
			prescale <= next_prescale;
			count1 <= next_count1;
			count2 <= next_count2;
			reload <= next_reload;
			capture <= next_capture;
			period_half <= next_period_half;
			cnt2_mask <= next_cnt2_mask;
			cap_mask <= next_cap_mask;
			period_sel <= next_period_sel;
			cnt1_mask <= next_cnt1_mask;
			irq_mask <= next_irq_mask;
			irq_status <= next_irq_status;
		end
	end

	// pin history; first sample taken after release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_q <= 1'b0;
			pin_seen <= 1'b0;
		end
		else
		begin
			pin_q <= capture_input_pin;
			pin_seen <= 1'b1;
		end
	end

	// ****************************************
	// read mux and outputs
	// ****************************************
	logic [7:0] rd_byte;
	logic next_irq1;
	logic next_irq2;
	logic next_irqc;
	always_comb
	begin
		rd_byte = 8'h00;
		if (is_reg(paddr, ltct_pkg::OFS_CSR2))
			rd_byte = {6'h00, cnt2_mask, cnt2_flag};
		else if (is_reg(paddr, ltct_pkg::OFS_RELOAD))
			rd_byte = reload;
		else if (is_reg(paddr, ltct_pkg::OFS_CNT2))
			rd_byte = count2;
		else if (is_reg(paddr, ltct_pkg::OFS_CSR1))
			rd_byte = {cap_mask, cap_flag, period_sel, cnt1_mask,
				cnt1_flag, 3'h0};
		else if (is_reg(paddr, ltct_pkg::OFS_CAPTURE))
			rd_byte = capture;
		else if (is_reg(paddr, ltct_pkg::OFS_IRQ_STATUS))
			rd_byte = {5'h00, irq_status};
		else if (is_reg(paddr, ltct_pkg::OFS_IRQ_MASK))
			rd_byte = {5'h00, irq_mask};
		next_irq1 = next_cnt1_mask && (cnt1_flag || ovf1);
		next_irq2 = next_cnt2_mask && (cnt2_flag || ovf2);
		next_irqc = next_cap_mask && (cap_flag || cap_event);
	end

	// zero-wait-state slave; outputs from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq_counter1 <= 1'b0;
			irq_counter2 <= 1'b0;
			irq_capture <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= setup ? {24'h000000, rd_byte} : 32'h0000_0000;
			// flags clear on read, so drop request on that read
			irq_counter1 <= next_irq1 && !(clr1 && !ovf1);
			irq_counter2 <= next_irq2 && !(clr2 && !ovf2);
			irq_capture <= next_irqc && !(clrc && !cap_event);
			irq <= |(next_irq_status & next_irq_mask);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_CNT1_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
		cnt1_wrap |=> count1 == 8'h00)
		else $error("counter1 did not wrap to zero");
	AST_CNT1_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
		count1 <= 8'hf9)
		else $error("counter1 above wrap value");
	AST_CNT2_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
		ovf2 |=> count2 == $past(reload))
		else $error("counter2 not reloaded");
	AST_CNT2_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		ovf2 |=> cnt2_flag)
		else $error("counter2 flag not set");
	AST_CAP_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
		cap_event |=> capture == $past(count1) && cap_flag)
		else $error("capture not latched");
	AST_CAP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		cap_flag && !clrc
		|=> $stable(capture))
		else $error("capture changed while flag set");
	AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
		halt_mode |=> $stable(count1) && $stable(count2))
		else $error("counters moved in halt");
	AST_IRQ2: assert property (@(posedge pclk) disable iff (!presetn)
		!cnt2_mask && !next_cnt2_mask |=> !irq_counter2)
		else $error("masked counter2 request raised");
	AST_CSR2_RSV: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && is_reg(paddr, ltct_pkg::OFS_CSR2)
		|-> prdata[7:2] == 6'h00)
		else $error("reserved bits not zero");
	AST_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
		ovf1 |-> cnt1_wrap)
		else $error("overflow outside wrap");
endmodule
`default_nettype wire

// >>> verif/ltct_edge_src.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// capture pin source
// ****************************************
module ltct_edge_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic flip,
	output logic pin
);
	// one pin edge per request, level held between
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin <= 1'b0;
		else if (flip)
			pin <= ~pin;
	end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	// ****************************************
	// signals and parts
	// ****************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr, pin, flip, halt_mode;
	logic irq_counter1, irq_counter2, irq_capture, irq;
	logic [2:0] iv;
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	localparam logic [11:0] A_CSR2 = ltct_pkg::OFS_CSR2 << 2;
	localparam logic [11:0] A_REL = ltct_pkg::OFS_RELOAD << 2;
	localparam logic [11:0] A_CNT2 = ltct_pkg::OFS_CNT2 << 2;
	localparam logic [11:0] A_CSR1 = ltct_pkg::OFS_CSR1 << 2;
	localparam logic [11:0] A_CAP = ltct_pkg::OFS_CAPTURE << 2;
	localparam logic [11:0] A_IST = ltct_pkg::OFS_IRQ_STATUS << 2;
	localparam logic [11:0] A_IMK = ltct_pkg::OFS_IRQ_MASK << 2;
	assign iv = {irq_capture, irq_counter2, irq_counter1};
	ltct_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_input_pin(pin),
		.halt_mode(halt_mode), .irq_counter1(irq_counter1),
		.irq_counter2(irq_counter2), .irq_capture(irq_capture),
		.irq(irq));
	ltct_edge_src src (.pclk(pclk), .presetn(presetn), .flip(flip),
		.pin(pin));
	// clock and cycle count
	always #20 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	// ****************************************
	// tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] r, output logic er);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the slave; only the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic er;
		apb(1'b1, a, d, r, er);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic er;
		apb(1'b0, a, 8'h00, r, er);
	endtask
	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		logic [31:0] r;
		rd(a, r);
		chk(nm, e, r);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic wt(input int s, output int t);
		int n;
		n = 0;
		while (n < 20000 && iv[s] !== 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		if (iv[s] !== 1'b1)
		begin
			failures++;
			$display("unexpected irq wait expected 1 seen 0");
		end
		t = cyc;
	endtask
	task automatic edge_pin();
		flip <= 1'b1;
		@(posedge pclk);
		flip <= 1'b0;
		@(posedge pclk);
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		logic [31:0] v, v3;
		logic er;
		int t0, t1;
		flip <= 1'b0;
		halt_mode <= 1'b0;
		step(12);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc("capture reset", A_CAP, 32'h0);
		rdc("csr2 reset", A_CSR2, 32'h0);
		rdc("reload reset", A_REL, 32'h0);
		rdc("imask reset", A_IMK, 32'h7);
		apb(1'b0, 12'h0fc, 8'h00, v, er);
		chk("unmapped err", 32'h1, {31'h0, er});
		wr(A_REL, 8'hfe);
		wr(A_CSR2, 8'h03);
		rdc("csr2 flag write", A_CSR2, 32'h2);
		wt(1, t0);
		rdc("csr2 overflow", A_CSR2, 32'h3);
		wr(A_CNT2, 8'h10);
		rd(A_CNT2, v);
		chk("cnt2 reloaded", 32'h1, {31'h0, v >= 32'hfe});
		halt_mode <= 1'b1;
		rd(A_CNT2, v);
		step(100);
		rdc("cnt2 halted", A_CNT2, v);
		halt_mode <= 1'b0;
		wr(A_CSR1, 8'h10);
		rd(A_CSR1, v);
		wt(0, t0);
		rd(A_CSR1, v);
		wt(0, t1);
		chk("period 0", 32'd8000, 32'(t1 - t0));
		wr(A_CSR1, 8'h30);
		rd(A_CSR1, v);
		wt(0, t0);
		rd(A_CSR1, v);
		wt(0, t1);
		chk("period 1", 32'd16000, 32'(t1 - t0));
		wr(A_CSR1, 8'h20);
		chk("c1 masked", 32'h0, {31'h0, irq_counter1});
		rdc("c1 flag kept", A_CSR1, 32'h28);
		wr(A_CSR1, 8'h80);
		edge_pin();
		step(2);
		chk("cap irq", 32'h1, {31'h0, irq_capture});
		rdc("cap flag", A_CSR1, 32'hc0);
		step(320);
		edge_pin();
		step(320);
		rd(A_CAP, v);
		edge_pin();
		step(2);
		rd(A_CAP, v3);
		chk("cap gap", 32'h1, {31'h0, ((v3[7:0] + 250 - v[7:0]) % 250) inside {[19:21]}});
		wr(A_IMK, 8'h00);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(A_IMK, 8'h04);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(A_IST, 8'h04);
		step(1);
		chk("irq cleared", 32'h0, {31'h0, irq});
		close_out();
	end
	// watchdog
	initial
	begin
		step(90000);
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
